// ===== hw/lmr_regs.sv
// Summary of operation
// - age stamp shows searched address's last sighting
// - multi-bit command writes are ignored
// - control access stalls until search finishes
// - match flag bit 7 marks valid results
// - scan-from-start finds first valid entry
// - scan-onward finds next entry after key
// - exact search sets or clears match flag
// - counters read-only, zero after reset
// - violation counter clears on read, flags MSB
// - unicast flood counter clears on high read
// - group flood counter clears on high read
// - entry counter tracks table population
// - auto-step bumps pointer after high access
// - 21-bit location field is host read/write
// - pointer bits 22-21 ignore writes, read zero
// - key writes blocked while command pending
// - high data byte write launches SRAM write
// - half-full violation and flood counters raise statistics event
module lmr_regs
  import lmr_pkg::*;
#(
  parameter int TABLE_DEPTH = 1024,
  parameter int IDX_W       = 10
)(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             hostReq,
  input  wire logic             hostWrite,
  input  wire logic [7:0]       hostAddr,
  input  wire logic [7:0]       hostWrData,
  output logic [7:0]            hostRdData,
  output logic                  hostCycleDone,
  input  wire logic [47:0]      searchKey,
  output logic                  keyLock,
  output logic                  resultLoad,
  output logic [47:0]           resultKey,
  output logic [15:0]           resultRoute,
  output logic [IDX_W-1:0]      tblIdx,
  output logic                  tblRdReq,
  input  wire logic             tblAck,
  input  wire logic             tblValid,
  input  wire logic [47:0]      tblKey,
  input  wire logic [15:0]      tblRoute,
  input  wire logic [15:0]      tblAge,
  input  wire logic             secViolationEvt,
  input  wire logic             floodUnicastEvt,
  input  wire logic             floodGroupEvt,
  input  wire logic             entryAddEvt,
  input  wire logic             entryDropEvt,
  output logic                  statEvent,
  output logic [PTR_LOC_W-1:0]  memAddr,
  output logic                  memWrStrobe,
  output logic                  memRdStrobe,
  output logic [15:0]           memWrData,
  input  wire logic [15:0]      memRdData
);
  // the index must reach every table entry
  if (TABLE_DEPTH < 2 || (2 ** IDX_W) < TABLE_DEPTH)
  begin : g_chk
    $error("lmr_regs: TABLE_DEPTH must be at least 2 and fit IDX_W");
  end

  typedef struct packed {
    logic                 reqS1;
    logic                 reqS2;
    logic                 wrS1;
    logic                 wrS2;
    logic [7:0]           addrS1;
    logic [7:0]           addrS2;
    logic [7:0]           dataS1;
    logic [7:0]           dataS2;
    logic                 seen;
    logic                 pend;
    logic                 cycDone;
    logic [7:0]           rdData;
    logic [2:0]           cmd;
    logic                 start;
    logic                 found;
    logic [15:0]          age;
    logic                 keyLock;
    logic                 resultLoad;
    logic [47:0]          resultKey;
    logic [15:0]          resultRoute;
    logic [7:0]           viol;
    logic [15:0]          uni;
    logic [15:0]          grp;
    logic [15:0]          nodes;
    logic                 stat;
    logic                 ptrStep;
    logic [PTR_LOC_W-1:0] ptrLoc;
    logic [7:0]           wordLo;
    logic [PTR_LOC_W-1:0] memAddr;
    logic                 memWr;
    logic                 memRd;
    logic [15:0]          memWrData;
  } lmr_regs_t;

  lmr_regs_t st;
  lmr_regs_t next_st;

  lmr_srch_if srch ();

  lmr_search #(
    .DEPTH    (TABLE_DEPTH),
    .IDX_W    (IDX_W)
  ) u_search (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .srch     (srch.eng),
    .tblIdx   (tblIdx),
    .tblRdReq (tblRdReq),
    .tblAck   (tblAck),
    .tblValid (tblValid),
    .tblKey   (tblKey),
    .tblRoute (tblRoute),
    .tblAge   (tblAge)
  );

  assign srch.start = st.start;
  assign srch.cmd   = st.cmd;
  assign srch.key   = searchKey;

  // saturating count; an event in the clearing cycle survives
  function automatic logic [15:0] bump(
    input logic [15:0] cur,
    input logic [15:0] top,
    input logic        evt,
    input logic        clr
  );
    logic [15:0] base;
    base = clr ? RST_WORD : cur;
    if (evt && base != top)
      bump = base + 16'h0001;
    else
      bump = base;
  endfunction : bump

  function automatic logic one_hot3(input logic [2:0] v);
    one_hot3 = (v == 3'h1) || (v == 3'h2) || (v == 3'h4);
  endfunction : one_hot3

  // population count; an add and a drop in one cycle cancel
  function automatic logic [15:0] track(
    input logic [15:0] cur,
    input logic        add,
    input logic        drop
  );
    if (add && !drop && cur != 16'hFFFF)
      track = cur + 16'h0001;
    else if (drop && !add && cur != RST_WORD)
      track = cur - 16'h0001;
    else
      track = cur;
  endfunction : track

  logic newReq;
  logic stall;
  logic access;
  logic rdAcc;
  logic wrAcc;
  logic violClr;
  logic uniClr;
  logic grpClr;
  logic stepPtr;
  logic [15:0] violWide;

  always_comb
  begin
    next_st = st;
    // request synchroniser
    next_st.reqS1 = hostReq;
    next_st.reqS2 = st.reqS1;
    // address, direction and data are held with the request, so they settle with it
    next_st.wrS1 = hostWrite;
    next_st.wrS2 = st.wrS1;
    next_st.addrS1 = hostAddr;
    next_st.addrS2 = st.addrS1;
    next_st.dataS1 = hostWrData;
    next_st.dataS2 = st.dataS1;
    next_st.cycDone = 1'b0;
    next_st.start = 1'b0;
    next_st.resultLoad = 1'b0;
    next_st.memWr = 1'b0;
    next_st.memRd = 1'b0;
    violClr = 1'b0;
    uniClr = 1'b0;
    grpClr = 1'b0;
    stepPtr = 1'b0;
    if (!st.reqS2)
      next_st.seen = 1'b0;

    // one access per rising level of the synchronised request
    newReq = st.reqS2 && !st.seen;
    // control access waits until the engine is idle again
    stall = st.addrS2 == OFS_CTRL && st.cmd != RST_CMD;
    access = (st.pend || newReq) && !stall;
    rdAcc = access && !st.wrS2;
    wrAcc = access && st.wrS2;
    if (newReq)
    begin
      next_st.seen = 1'b1;
      next_st.pend = 1'b1;
    end
    if (access)
    begin
      next_st.pend = 1'b0;
      next_st.cycDone = 1'b1;
    end

    // read decode
    if (rdAcc)
    begin
      case (st.addrS2)
        OFS_AGE_LO: next_st.rdData = st.age[7:0];
        OFS_AGE_HI: next_st.rdData = st.age[15:8];
        OFS_CTRL:   next_st.rdData = {st.found, 4'h0, st.cmd};
        OFS_VIOL:
        begin
          next_st.rdData = st.viol;
          violClr = 1'b1;
        end
        OFS_UNI_LO: next_st.rdData = st.uni[7:0];
        OFS_UNI_HI:
        begin
          next_st.rdData = st.uni[15:8];
          uniClr = 1'b1;
        end
        OFS_GRP_LO: next_st.rdData = st.grp[7:0];
        OFS_GRP_HI:
        begin
          next_st.rdData = st.grp[15:8];
          grpClr = 1'b1;
        end
        OFS_CNT_LO: next_st.rdData = st.nodes[7:0];
        OFS_CNT_HI: next_st.rdData = st.nodes[15:8];
        OFS_PTR_B0: next_st.rdData = st.ptrLoc[7:0];
        OFS_PTR_B1: next_st.rdData = st.ptrLoc[15:8];
        OFS_PTR_B2: next_st.rdData = {st.ptrStep, 2'b00, st.ptrLoc[20:16]};
        OFS_WORD_LO:
        begin
          next_st.rdData = memRdData[7:0];
          next_st.memAddr = st.ptrLoc;
          next_st.memRd = 1'b1;
        end
        OFS_WORD_HI:
        begin
          next_st.rdData = memRdData[15:8];
          next_st.memAddr = st.ptrLoc;
          next_st.memRd = 1'b1;
          stepPtr = 1'b1;
        end
        default:    next_st.rdData = RST_BYTE;
      endcase
    end

    // write decode
    if (wrAcc)
    begin
      case (st.addrS2)
        OFS_CTRL:
        begin
          if (one_hot3(st.dataS2[2:0]) && st.cmd == RST_CMD)
          begin
            next_st.cmd = st.dataS2[2:0];
            next_st.start = 1'b1;
            next_st.found = 1'b0;
          end
        end
        OFS_PTR_B0: next_st.ptrLoc[7:0] = st.dataS2;
        OFS_PTR_B1: next_st.ptrLoc[15:8] = st.dataS2;
        OFS_PTR_B2:
        begin
          next_st.ptrLoc[20:16] = st.dataS2[4:0];
          next_st.ptrStep = st.dataS2[PTR_STEP_BIT];
        end
        OFS_WORD_LO: next_st.wordLo = st.dataS2;
        OFS_WORD_HI:
        begin
          next_st.memWr = 1'b1;
          next_st.memAddr = st.ptrLoc;
          next_st.memWrData = {st.dataS2, st.wordLo};
          stepPtr = 1'b1;
        end
        default:
        begin
          next_st.wordLo = st.wordLo;
        end
      endcase
    end
    if (stepPtr && st.ptrStep)
      next_st.ptrLoc = next_st.ptrLoc + 1'b1;

    // search completion
    if (srch.done)
    begin
      next_st.cmd = RST_CMD;
      next_st.found = srch.found;
      next_st.age = srch.found ? srch.resAge : RST_WORD;
      next_st.resultLoad = srch.found;
      next_st.resultKey = srch.resKey;
      next_st.resultRoute = srch.resRoute;
    end

    // key lock follows the next command so it rises with the start pulse
    next_st.keyLock = next_st.cmd != RST_CMD;

    // statistics counters
    violWide = bump({8'h00, st.viol}, 16'h00FF, secViolationEvt, violClr);
    next_st.viol = violWide[7:0];
    next_st.uni = bump(st.uni, 16'hFFFF, floodUnicastEvt, uniClr);
    next_st.grp = bump(st.grp, 16'hFFFF, floodGroupEvt, grpClr);
    next_st.nodes = track(st.nodes, entryAddEvt, entryDropEvt);
    next_st.stat = next_st.viol[7] | next_st.uni[15] | next_st.grp[15];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.ptrLoc <= RST_LOC;
      st.cmd <= RST_CMD;
      st.resultKey <= RST_KEY;
    end
    else
      st <= next_st;
  end

  assign hostRdData    = st.rdData;
  assign hostCycleDone = st.cycDone;
  assign keyLock       = st.keyLock;
  assign resultLoad    = st.resultLoad;
  assign resultKey     = st.resultKey;
  assign resultRoute   = st.resultRoute;
  assign statEvent     = st.stat;
  assign memAddr       = st.memAddr;
  assign memWrStrobe   = st.memWr;
  assign memRdStrobe   = st.memRd;
  assign memWrData     = st.memWrData;
endmodule : lmr_regs

// ===== hw/lmr_pkg.sv
package lmr_pkg;
  // byte offsets on the host direct port
  localparam logic [7:0]  OFS_AGE_LO   = 8'h14;
  localparam logic [7:0]  OFS_AGE_HI   = 8'h15;
  localparam logic [7:0]  OFS_CTRL     = 8'h16;
  localparam logic [7:0]  OFS_VIOL     = 8'h17;
  localparam logic [7:0]  OFS_UNI_LO   = 8'h18;
  localparam logic [7:0]  OFS_UNI_HI   = 8'h19;
  localparam logic [7:0]  OFS_GRP_LO   = 8'h1A;
  localparam logic [7:0]  OFS_GRP_HI   = 8'h1B;
  localparam logic [7:0]  OFS_CNT_LO   = 8'h1C;
  localparam logic [7:0]  OFS_CNT_HI   = 8'h1D;
  localparam logic [7:0]  OFS_PTR_B0   = 8'h20;
  localparam logic [7:0]  OFS_PTR_B1   = 8'h21;
  localparam logic [7:0]  OFS_PTR_B2   = 8'h22;
  localparam logic [7:0]  OFS_WORD_LO  = 8'h24;
  localparam logic [7:0]  OFS_WORD_HI  = 8'h25;
  // field positions
  localparam int          CMD_EXACT    = 0;
  localparam int          CMD_ONWARD   = 1;
  localparam int          CMD_START    = 2;
  localparam int          MATCH_BIT    = 7;
  localparam int          PTR_STEP_BIT = 7;
  localparam int          PTR_LOC_W    = 21;
  // values after reset
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  localparam logic [20:0] RST_LOC      = 21'h000000;
  localparam logic [47:0] RST_KEY      = 48'h000000000000;
  localparam logic [2:0]  RST_CMD      = 3'h0;
  // longest search stall
  localparam int          STALL_MAX_NS = 6400;
  localparam int          CLK_NS       = 40;
  localparam int          STALL_CYC    = (STALL_MAX_NS / CLK_NS) < 1 ? 1 : (STALL_MAX_NS / CLK_NS);
  localparam int          TMR_W        = $clog2(STALL_CYC + 1);
  typedef enum logic [1:0] {
    SE_IDLE = 2'b00,
    SE_READ = 2'b01,
    SE_WAIT = 2'b10,
    SE_DONE = 2'b11
  } lmr_se_state_t;
endpackage : lmr_pkg

// ===== hw/lmr_srch_if.sv
interface lmr_srch_if;
  logic        start;
  logic [2:0]  cmd;
  logic [47:0] key;
  logic        done;
  logic        found;
  logic [47:0] resKey;
  logic [15:0] resRoute;
  logic [15:0] resAge;
  modport ctl (output start, cmd, key, input done, found, resKey, resRoute, resAge);
  modport eng (input start, cmd, key, output done, found, resKey, resRoute, resAge);
endinterface : lmr_srch_if

// ===== hw/lmr_search.sv
module lmr_search
  import lmr_pkg::*;
#(
  parameter int DEPTH = 1024,
  parameter int IDX_W = 10
)(
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  lmr_srch_if.eng               srch,
  output logic [IDX_W-1:0]      tblIdx,
  output logic                  tblRdReq,
  input  wire logic             tblAck,
  input  wire logic             tblValid,
  input  wire logic [47:0]      tblKey,
  input  wire logic [15:0]      tblRoute,
  input  wire logic [15:0]      tblAge
);
  if (DEPTH < 2 || (2 ** IDX_W) < DEPTH)
  begin : g_chk
    $error("lmr_search: DEPTH must be at least 2 and fit IDX_W");
  end

  typedef struct packed {
    lmr_se_state_t    state;
    logic [IDX_W-1:0] idx;
    logic [2:0]       cmd;
    logic             passed;
    logic [TMR_W-1:0] timer;
    logic             rdReq;
    logic             done;
    logic             found;
    logic [47:0]      resKey;
    logic [15:0]      resRoute;
    logic [15:0]      resAge;
  } lmr_se_t;

  lmr_se_t st;
  lmr_se_t next_st;
  logic    hit;

  always_comb
  begin
    next_st = st;
    next_st.done = 1'b0;
    next_st.rdReq = 1'b0;
    hit = 1'b0;
    case (st.state)
      SE_IDLE:
      begin
        if (srch.start)
        begin
          next_st.cmd = srch.cmd;
          next_st.idx = '0;
          next_st.passed = 1'b0;
          next_st.timer = '0;
          next_st.found = 1'b0;
          next_st.state = SE_READ;
        end
      end
      SE_READ:
      begin
        next_st.rdReq = 1'b1;
        next_st.timer = st.timer + 1'b1;
        next_st.state = SE_WAIT;
      end
      SE_WAIT:
      begin
        next_st.timer = st.timer + 1'b1;
        if (st.timer >= TMR_W'(STALL_CYC - 1))
          next_st.state = SE_DONE;
        else if (tblAck)
        begin
          if (st.cmd[CMD_EXACT])
            hit = tblValid && tblKey == srch.key;
          else if (st.cmd[CMD_START])
            hit = tblValid;
          else
            hit = tblValid && st.passed;
          if (tblValid && tblKey == srch.key)
            next_st.passed = 1'b1;
          if (hit)
          begin
            next_st.found = 1'b1;
            next_st.resKey = tblKey;
            next_st.resRoute = tblRoute;
            next_st.resAge = tblAge;
            next_st.state = SE_DONE;
          end
          else if (st.idx == IDX_W'(DEPTH - 1))
            next_st.state = SE_DONE;
          else
          begin
            next_st.idx = st.idx + 1'b1;
            next_st.state = SE_READ;
          end
        end
      end
      SE_DONE:
      begin
        next_st.done = 1'b1;
        next_st.state = SE_IDLE;
      end
      default:
        next_st.state = SE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.state <= SE_IDLE;
    end
    else
      st <= next_st;
  end

  assign tblIdx        = st.idx;
  assign tblRdReq      = st.rdReq;
  assign srch.done     = st.done;
  assign srch.found    = st.found;
  assign srch.resKey   = st.resKey;
  assign srch.resRoute = st.resRoute;
  assign srch.resAge   = st.resAge;
endmodule : lmr_search

// ===== tb/lmr_regs_sva.sv
module lmr_regs_sva
  import lmr_pkg::*;
(
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       hostReq,
  input wire logic       hostWrite,
  input wire logic [7:0] hostAddr,
  input wire logic [7:0] hostWrData,
  input wire logic [7:0] hostRdData,
  input wire logic       hostCycleDone,
  input wire logic       keyLock,
  input wire logic       resultLoad,
  input wire logic       memWrStrobe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_done_pulse;
    hostCycleDone |=> !hostCycleDone ##1 !hostCycleDone;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_ctl_rd_wait;
    hostCycleDone && !hostWrite && hostAddr == OFS_CTRL |-> !keyLock;
  endproperty
  a_ctl_rd_wait: assert property (p_ctl_rd_wait) else $error("control read during search");
  property p_multi_cmd;
    hostCycleDone && hostWrite && hostAddr == OFS_CTRL && $countones(hostWrData[2:0]) != 1
      |-> ##1 !keyLock [*4];
  endproperty
  a_multi_cmd: assert property (p_multi_cmd) else $error("bad command started");
  property p_lock_set;
    hostCycleDone && hostWrite && hostAddr == OFS_CTRL && $countones(hostWrData[2:0]) == 1
      |-> ##[0:2] keyLock;
  endproperty
  a_lock_set: assert property (p_lock_set) else $error("key not locked");
  property p_self_clear;
    $rose(keyLock) |-> ##[1:170] !keyLock;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("command never clears");
  property p_load_in_search;
    resultLoad |-> keyLock || $past(keyLock);
  endproperty
  a_load_in_search: assert property (p_load_in_search) else $error("stray result load");
  property p_rsv_zero;
    hostCycleDone && !hostWrite && hostAddr == OFS_PTR_B2 |-> hostRdData[6:5] == 2'h0;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
  property p_wr_launch;
    memWrStrobe |-> hostReq && hostWrite && hostAddr == OFS_WORD_HI;
  endproperty
  a_wr_launch: assert property (p_wr_launch) else $error("stray memory write");
endmodule : lmr_regs_sva

// ===== tb/lmr_tbl_model.sv
module lmr_tbl_model
#(
  parameter int DEPTH = 8,
  parameter int IDX_W = 3
)(
  input  wire logic             clk_sys,
  input  wire logic [IDX_W-1:0] tblIdx,
  input  wire logic             tblRdReq,
  input  wire logic [1:0]       lat,
  output logic                  tblAck,
  output logic                  tblValid,
  output logic [47:0]           tblKey,
  output logic [15:0]           tblRoute,
  output logic [15:0]           tblAge
);
  timeunit 1ns;
  timeprecision 1ns;
  // entry layout: valid, key, route, age
  logic [80:0]      ent [DEPTH];
  logic [IDX_W-1:0] idx;
  int               cnt = -1;
  always @(posedge clk_sys)
  begin
    tblAck <= 1'b0;
    if (tblRdReq)
    begin
      idx = tblIdx;
      cnt = int'(lat);
    end
    if (cnt == 0)
    begin
      tblAck <= 1'b1;
      {tblValid, tblKey, tblRoute, tblAge} <= ent[idx];
    end
    else
      {tblValid, tblKey, tblRoute, tblAge} <= ~{tblValid, tblKey, tblRoute, tblAge};
    if (cnt >= 0)
      cnt--;
  end
endmodule : lmr_tbl_model

// ===== tb/lmr_regs_tb.sv
`define CHK(nm, ex, sn) \
  begin \
    checks++; \
    if ((sn) !== (ex)) \
    begin \
      miscompares++; \
      $display("wrong value %s exp %0h got %0h", nm, ex, sn); \
    end \
  end
module lmr_regs_tb
  import lmr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst_n, hostReq, hostWrite, hostCycleDone, keyLock, resultLoad, tblRdReq;
  logic        tblAck, tblValid, statEvent, memWrStrobe, memRdStrobe;
  logic [7:0]  hostAddr, hostWrData, hostRdData, rd, lo;
  logic [47:0] searchKey, resultKey, tblKey;
  logic [15:0] resultRoute, tblRoute, tblAge, memWrData, memRdData, wrSeen, d;
  logic [2:0]  tblIdx;
  logic [20:0] memAddr, p;
  logic [4:0]  evt;
  logic [1:0]  lat;
  logic [80:0] e [3];
  int          miscompares, checks, hits, reqs, rds, n;
  lmr_regs #(.TABLE_DEPTH(8), .IDX_W(3)) dut_u (.clk_sys, .rst_n, .hostReq, .hostWrite, .hostAddr,
    .hostWrData, .hostRdData, .hostCycleDone, .searchKey, .keyLock, .resultLoad, .resultKey, .resultRoute,
    .tblIdx, .tblRdReq, .tblAck, .tblValid, .tblKey, .tblRoute, .tblAge, .secViolationEvt(evt[0]),
    .floodUnicastEvt(evt[1]), .floodGroupEvt(evt[2]), .entryAddEvt(evt[3]), .entryDropEvt(evt[4]),
    .statEvent, .memAddr, .memWrStrobe, .memRdStrobe, .memWrData, .memRdData);
  lmr_tbl_model tbl_u (.clk_sys, .tblIdx, .tblRdReq, .lat, .tblAck, .tblValid, .tblKey, .tblRoute, .tblAge);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
  begin
    hits += int'(resultLoad);
    reqs += int'(tblRdReq);
    rds += int'(memRdStrobe);
    if (memWrStrobe)
      wrSeen <= memWrData;
  end
  task end_of_test();
    if (miscompares == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  // one host access, request held until the done pulse is seen
  task acc(input logic w, input logic [7:0] a, input logic [7:0] v);
    int t;
    @(negedge clk_sys);
    {hostReq, hostWrite, hostAddr, hostWrData} = {1'b1, w, a, v};
    t = 0;
    do @(negedge clk_sys); while (hostCycleDone !== 1'b1 && ++t < 400);
    rd = hostRdData;
    if (t >= 400)
      miscompares++;
    // hold the request through the edge that samples the done pulse
    @(posedge clk_sys);
    @(negedge clk_sys);
    hostReq = 1'b0;
    repeat (2) @(negedge clk_sys);
  endtask : acc
  task rdx(input logic [7:0] a, input logic [7:0] ex);
    acc(1'b0, a, 8'h00);
    `CHK($sformatf("byte %h", a), ex, rd)
  endtask : rdx
  task pulse(input int k, input int cnt);
    repeat (cnt)
    begin
      @(negedge clk_sys) evt[k] = 1'b1;
      @(negedge clk_sys) evt[k] = 1'b0;
    end
  endtask : pulse
  task srch(input logic [2:0] c, input logic [47:0] k, input logic [7:0] ex);
    searchKey = k;
    lat = 2'($urandom);
    acc(1'b1, OFS_CTRL, {5'h00, c});
    rdx(OFS_CTRL, ex);
  endtask : srch
  initial
  begin
    #(40ns * 20000);
    miscompares++;
    end_of_test();
  end
  initial
  begin
    {clk_sys, rst_n, hostReq, hostWrite, hostAddr, hostWrData, searchKey, evt, memRdData, lat} = '0;
    {miscompares, checks, hits, reqs, rds} = '0;
    void'($urandom(32'h2A30));
    for (int i = 0; i < 8; i++)
      tbl_u.ent[i] = '0;
    for (int i = 0; i < 3; i++)
      e[i] = {1'b1, 16'($urandom), 32'($urandom), 32'($urandom)};
    {tbl_u.ent[1], tbl_u.ent[4], tbl_u.ent[6]} = {e[0], e[1], e[2]};
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    for (int a = 8'h14; a < 8'h31; a++)
      rdx(8'(a), RST_BYTE);
    for (int k = 0; k < 3; k++)
    begin
      n = $urandom_range(100, 1);
      pulse(k, n);
      lo = (k == 0) ? OFS_VIOL : OFS_VIOL + 8'(2 * k - 1);
      rdx(lo, 8'(n));
      if (k > 0)
        rdx(lo + 8'h01, 8'h00);
      rdx(lo, 8'h00);
    end
    pulse(0, 128);
    `CHK("statEvent", 1'b1, statEvent)
    rdx(OFS_VIOL, 8'h80);
    `CHK("statEvent", 1'b0, statEvent)
    pulse(3, 5);
    pulse(4, 2);
    rdx(OFS_CNT_LO, 8'h03);
    acc(1'b1, OFS_CNT_LO, 8'hFF);
    rdx(OFS_CNT_LO, 8'h03);
    p = 21'($urandom);
    acc(1'b1, OFS_PTR_B0, p[7:0]);
    acc(1'b1, OFS_PTR_B1, p[15:8]);
    acc(1'b1, OFS_PTR_B2, {3'h7, p[20:16]});
    rdx(OFS_PTR_B2, {3'h4, p[20:16]});
    rdx(OFS_PTR_B0, p[7:0]);
    rdx(OFS_PTR_B1, p[15:8]);
    d = 16'($urandom);
    acc(1'b1, OFS_WORD_LO, d[7:0]);
    acc(1'b1, OFS_WORD_HI, d[15:8]);
    `CHK("memWrData", d, wrSeen)
    `CHK("memAddr", p, memAddr)
    memRdData = ~d;
    rdx(OFS_WORD_HI, ~d[15:8]);
    `CHK("memAddr", p + 21'h1, memAddr)
    rdx(OFS_PTR_B0, 8'(p + 21'h2));
    srch(3'h1, e[1][79:32], 8'h80);
    rdx(OFS_AGE_LO, e[1][7:0]);
    rdx(OFS_AGE_HI, e[1][15:8]);
    `CHK("route", e[1][31:16], resultRoute)
    srch(3'h1, ~e[1][79:32], 8'h00);
    srch(3'h4, 48'h0, 8'h80);
    `CHK("key", e[0][79:32], resultKey)
    srch(3'h2, e[0][79:32], 8'h80);
    `CHK("key", e[1][79:32], resultKey)
    srch(3'h2, e[2][79:32], 8'h00);
    n = reqs;
    acc(1'b1, OFS_CTRL, 8'h06);
    acc(1'b1, OFS_CTRL, 8'h00);
    `CHK("reqs", n, reqs)
    `CHK("hits", 3, hits)
    `CHK("rdStrobes", 3, rds)
    end_of_test();
  end
endmodule : lmr_regs_tb
bind lmr_regs lmr_regs_sva chk_u (.clk_sys, .rst_n, .hostReq, .hostWrite, .hostAddr, .hostWrData,
  .hostRdData, .hostCycleDone, .keyLock, .resultLoad, .memWrStrobe);
